// File: core/dma_channel_size_pointer_regs.sv
// DMA channel length and progress logic with an APB register slave
// Notes on behaviour
// (RULE1) Destination length counts bytes; 1 is one byte, zero is 65,536.
// (RULE2) Upper sixteen bits of length and pointer registers read zero, ignore writes.
// (RULE3) Read-only source pointer gives index of current source byte.
// (RULE4) Read-only destination pointer gives index of current destination byte.
// (RULE5) In pattern-detect mode a match clears both pointers.
// (RULE6) Each trigger event moves cell-length bytes.
// (RULE7) Source length counts bytes like destination length; zero is 65,536.
// (RULE8) Pattern-terminate mode ends transfer on match with 8-bit value; otherwise ignored.
// (RULE9) Pointers step once per byte; side exhausted when pointer reaches its length.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "dma_size_regs.svh"
module dma_channel_size_pointer_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Byte mover
    input  wire logic        cell_trigger,
    output logic             byte_req,
    input  wire logic        byte_ack,
    input  wire logic [7:0]  byte_data,
    // Status
    output logic             transfer_done,
    output logic             busy
);

    progress_if src_if ();
    progress_if dst_if ();

    logic                    ctrl_enable;
    dma_size_pkg::mode_type  mode;
    logic [15:0]             source_length;
    logic [15:0]             destination_length;
    logic [15:0]             cell_length;
    logic [7:0]              match_value;
    logic                    done_flag;
    logic                    term_flag;
    logic [15:0]             cell_count;
    dma_size_pkg::state_type state;
    dma_size_pkg::state_type next_state;

    logic                    access;
    logic                    commit;
    logic                    wr_ctrl;
    logic                    start;
    logic                    moved;
    logic                    hit;
    logic                    detect_clear;
    logic                    term_hit;
    logic                    finish;
    logic                    cell_end;

    // Answer comes one cycle into the access phase
    assign access  = psel && penable && !pready;
    assign commit  = psel && penable && pready;
    assign wr_ctrl = commit && pwrite && (paddr == `ADDR_CONTROL);
    assign start   = wr_ctrl && pwdata[`CTRL_ENABLE_BIT] && (state == dma_size_pkg::st_idle);

    assign moved    = byte_req && byte_ack;
    assign hit      = moved && (byte_data == match_value);
    // (RULE5) detect mode match
    assign detect_clear = hit && (mode == dma_size_pkg::mode_detect);
    // (RULE8) terminate on match
    assign term_hit = hit && (mode == dma_size_pkg::mode_terminate);
    // (RULE9) destination exhausted ends it
    assign finish   = moved && (term_hit || dst_if.last);
    // (RULE6) cell boundary reached
    assign cell_end = moved && (cell_count == dma_size_pkg::final_index(cell_length));

    // (RULE3) source side counter
    assign src_if.clear  = start || detect_clear;
    assign src_if.step   = moved;
    // (RULE7) source length wrap
    assign src_if.length = source_length;
    // (RULE4) destination side counter
    assign dst_if.clear  = start || detect_clear;
    assign dst_if.step   = moved;
    // (RULE1) destination length wrap
    assign dst_if.length = destination_length;

    progress_counter src_counter (
        .clk  (clk),
        .srst (srst),
        .pc   (src_if.counter)
    );

    progress_counter dst_counter (
        .clk  (clk),
        .srst (srst),
        .pc   (dst_if.counter)
    );

    function automatic logic [31:0] read_word(input logic [7:0] addr);
        case (addr)
            `ADDR_CONTROL:      read_word = {29'h0, mode, ctrl_enable};
            `ADDR_STATUS:       read_word = {29'h0, term_flag, done_flag, busy};
            `ADDR_SRC_LENGTH:   read_word = {16'h0, source_length};
            `ADDR_DST_LENGTH:   read_word = {16'h0, destination_length};
            `ADDR_SRC_PROGRESS: read_word = {16'h0, src_if.pointer};
            `ADDR_DST_PROGRESS: read_word = {16'h0, dst_if.pointer};
            `ADDR_CELL_LENGTH:  read_word = {16'h0, cell_length};
            `ADDR_MATCH_VALUE:  read_word = {24'h0, match_value};
            default:            read_word = 32'h0;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr[1:0] == 2'h0) && (addr <= `ADDR_MATCH_VALUE);
    endfunction

    // APB answer
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access;
            pslverr <= access && !mapped(paddr);
            // (RULE2) upper half reads zero
            prdata  <= (access && !pwrite) ? read_word(paddr) : 32'h0;
        end
    end

    // Software-written fields; upper write bits are dropped
    always_ff @(posedge clk) begin
        if (srst) begin
            source_length      <= `LENGTH_RESET;
            destination_length <= `LENGTH_RESET;
            cell_length        <= `LENGTH_RESET;
            match_value        <= `MATCH_RESET;
            mode               <= dma_size_pkg::mode_normal;
        end else if (commit && pwrite) begin
            case (paddr)
                // (RULE2) low half only
                `ADDR_SRC_LENGTH:  source_length      <= pwdata[`FIELD_MSB:0];
                `ADDR_DST_LENGTH:  destination_length <= pwdata[`FIELD_MSB:0];
                `ADDR_CELL_LENGTH: cell_length        <= pwdata[`FIELD_MSB:0];
                `ADDR_MATCH_VALUE: match_value        <= pwdata[`MATCH_MSB:0];
                `ADDR_CONTROL:     mode <= dma_size_pkg::mode_type'(pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
                default:           ;
            endcase
        end
    end

    // Enable drops by itself when the transfer ends
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_enable <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_enable <= pwdata[`CTRL_ENABLE_BIT];
        end else if (finish) begin
            ctrl_enable <= 1'b0;
        end
    end

    // Sticky flags: a finish in the clearing cycle still sets done_flag, and a terminate finish also sets term_flag
    always_ff @(posedge clk) begin
        if (srst) begin
            done_flag <= 1'b0;
            term_flag <= 1'b0;
        end else begin
            if (finish) begin
                done_flag <= 1'b1;
            end else if (commit && pwrite && paddr == `ADDR_STATUS && pwdata[`STAT_DONE_BIT]) begin
                done_flag <= 1'b0;
            end
            if (finish && term_hit) begin
                term_flag <= 1'b1;
            end else if (commit && pwrite && paddr == `ADDR_STATUS && pwdata[`STAT_TERM_BIT]) begin
                term_flag <= 1'b0;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            dma_size_pkg::st_idle: begin
                if (start) begin
                    next_state = dma_size_pkg::st_wait;
                end
            end
            dma_size_pkg::st_wait: begin
                if (wr_ctrl && !pwdata[`CTRL_ENABLE_BIT]) begin
                    next_state = dma_size_pkg::st_idle;
                end else if (cell_trigger) begin
                    next_state = dma_size_pkg::st_moving;
                end
            end
            dma_size_pkg::st_moving: begin
                if (finish || (wr_ctrl && !pwdata[`CTRL_ENABLE_BIT])) begin
                    next_state = dma_size_pkg::st_idle;
                end else if (cell_end) begin
                    next_state = dma_size_pkg::st_wait;
                end
            end
            default: next_state = dma_size_pkg::st_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state         <= dma_size_pkg::st_idle;
            byte_req      <= 1'b0;
            busy          <= 1'b0;
            transfer_done <= 1'b0;
        end else begin
            state         <= next_state;
            byte_req      <= (next_state == dma_size_pkg::st_moving);
            busy          <= (next_state != dma_size_pkg::st_idle);
            transfer_done <= finish;
        end
    end

    // (RULE6) bytes within the current cell
    always_ff @(posedge clk) begin
        if (srst || state != dma_size_pkg::st_moving || cell_end) begin
            cell_count <= 16'h0000;
        end else if (moved) begin
            cell_count <= cell_count + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_dst_len_zero: assert property (moved && dst_if.last && !term_hit |=> transfer_done && dst_if.pointer == 16'h0) // RULE1
        else $error("destination did not end at its length");
    chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) // RULE2
        else $error("upper read bits not zero");
    chk_src_step: assert property (moved && !detect_clear && !src_if.last |=> src_if.pointer == $past(src_if.pointer) + 16'h0001) // RULE3
        else $error("source pointer did not step by one");
    chk_dst_step: assert property (moved && !detect_clear && !dst_if.last && !start |=> dst_if.pointer == $past(dst_if.pointer) + 16'h0001) // RULE4
        else $error("destination pointer did not step by one");
    chk_detect_clear: assert property (detect_clear |=> src_if.pointer == 16'h0 && dst_if.pointer == 16'h0) // RULE5
        else $error("pattern detect did not clear pointers");
    chk_cell_size: assert property (cell_end && !finish && !wr_ctrl |=> !byte_req && state == dma_size_pkg::st_wait) // RULE6
        else $error("cell did not stop at its length");
    chk_src_wrap: assert property (moved && src_if.last && !start |=> src_if.pointer == 16'h0) // RULE7
        else $error("source pointer did not wrap at its length");
    chk_term_end: assert property (term_hit |=> !busy && transfer_done && term_flag) // RULE8
        else $error("terminate match did not end transfer");
    chk_no_term: assert property (moved && mode != dma_size_pkg::mode_terminate && !dst_if.last && !cell_end && !wr_ctrl |=> busy ##0 byte_req) // RULE8
        else $error("match value acted outside terminate mode");
    chk_done_flag: assert property (finish |=> done_flag ##1 !transfer_done) // RULE9
        else $error("done flag not set on finish");

    cov_start:     cover property (start ##[1:40] cell_trigger);
    cov_detect:    cover property (detect_clear);
    cov_cell_wait: cover property (cell_end && !finish);
    cov_terminate: cover property (term_hit);

endmodule

// File: core/dma_size_regs.svh
// Register offsets, field positions and reset values of the channel size and pointer block
`ifndef DMA_SIZE_REGS_SVH
`define DMA_SIZE_REGS_SVH

`define ADDR_CONTROL      8'h00
`define ADDR_STATUS       8'h04
`define ADDR_SRC_LENGTH   8'h08
`define ADDR_DST_LENGTH   8'h0c
`define ADDR_SRC_PROGRESS 8'h10
`define ADDR_DST_PROGRESS 8'h14
`define ADDR_CELL_LENGTH  8'h18
`define ADDR_MATCH_VALUE  8'h1c

`define CTRL_ENABLE_BIT   0
`define CTRL_MODE_LSB     1
`define CTRL_MODE_MSB     2

`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1
`define STAT_TERM_BIT     2

`define FIELD_MSB         15
`define MATCH_MSB         7
`define LENGTH_RESET      16'h0000
`define MATCH_RESET       8'h00

`endif

// File: core/dma_size_pkg.sv
// Types and shared arithmetic of the channel size and pointer block
package dma_size_pkg;

    typedef enum logic [1:0] {
        mode_normal    = 2'h0,
        mode_detect    = 2'h1,
        mode_terminate = 2'h2
    } mode_type;

    typedef enum logic [1:0] {
        st_idle   = 2'h0,
        st_wait   = 2'h1,
        st_moving = 2'h3
    } state_type;

    // Index of the final byte; a length of zero wraps to 16'hffff, i.e. 65,536 bytes
    function automatic logic [15:0] final_index(input logic [15:0] len);
        final_index = len - 16'h0001;
    endfunction

endpackage

// File: core/progress_if.sv
// Signals between the channel control and one byte progress counter
`timescale 1ns/1ps
interface progress_if;
    logic        clear;
    logic        step;
    logic [15:0] length;
    logic [15:0] pointer;
    logic        last;

    modport counter (input clear, input step, input length, output pointer, output last);
    modport user    (output clear, output step, output length, input pointer, input last);
endinterface

// File: core/progress_counter.sv
// Byte progress counter for one side of a channel
`timescale 1ns/1ps
module progress_counter (
    // Clock and reset
    input wire logic      clk,
    input wire logic      srst,
    // Control side
    progress_if.counter   pc
);

    // (RULE9) final byte seen
    assign pc.last = (pc.pointer == dma_size_pkg::final_index(pc.length));

    // (RULE9) advance or restart
    always_ff @(posedge clk) begin
        if (srst || pc.clear) begin
            pc.pointer <= 16'h0000;
        end else if (pc.step) begin
            pc.pointer <= pc.last ? 16'h0000 : pc.pointer + 16'h0001;
        end
    end

endmodule

// File: tb/byte_mover_model.sv
// Memory-side model that answers the channel's byte requests
`timescale 1ns/1ps
module byte_mover_model (
    // Clock
    input  wire logic       clk,
    // Channel side
    output logic            byte_ack,
    output logic [7:0]      byte_data,
    input  wire logic       byte_req,
    // Bench control
    input  wire logic       slow,
    input  wire logic [7:0] fill
);
    logic [1:0] pace = 2'h0;
    logic       go;
    initial begin
        byte_ack  = 1'b0;
        byte_data = 8'h5a;
    end
    assign go = byte_req && !byte_ack && (!slow || pace == 2'h0);
    // Data toggles when not acked, so a stale byte never passes for a fresh one
    always @(posedge clk) begin
        pace      <= pace + 2'h1;
        byte_ack  <= go;
        byte_data <= go ? fill : ~byte_data;
    end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the channel length and progress block
`timescale 1ns/1ps
`include "dma_size_regs.svh"
module testbench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cell_trigger = 1'b0;
    logic        byte_req;
    logic        byte_ack;
    logic [7:0]  byte_data;
    logic        transfer_done;
    logic        busy;
    logic        slow = 1'b0;
    logic [7:0]  fill = 8'h00;
    int          failures = 0;
    int          checked = 0;
    int          acks = 0;
    int          dones = 0;
    int          cycles = 0;

    dma_channel_size_pointer_regs DUT (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_trigger(cell_trigger),
        .byte_req(byte_req), .byte_ack(byte_ack), .byte_data(byte_data), .transfer_done(transfer_done),
        .busy(busy)
    );
    byte_mover_model mover (
        .clk(clk), .byte_ack(byte_ack), .byte_data(byte_data), .byte_req(byte_req), .slow(slow), .fill(fill)
    );

    initial forever #12.5 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (byte_req === 1'b1 && byte_ack === 1'b1) acks <= acks + 1;
        if (transfer_done === 1'b1) dones <= dones + 1;
        if (cycles == 60000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic int eff(input logic [15:0] v);
        return (v == 16'h0) ? 65536 : int'(v);
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) failures++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        cmp32(nm, x, q);
        cmp32("slave error", 32'h0, {31'h0, e});
    endtask

    // One transfer: cells are triggered one by one and counted against the lengths
    task automatic run(input logic [1:0] md, input logic [15:0] dl, cl, sl, input logic [7:0] mt, input int cells);
        int          total, moved, a0, d0, n, want;
        logic        hit, clr;
        logic [31:0] q;
        logic        e;
        hit   = (fill == mt);
        clr   = (md == 2'h1) && hit;
        total = (md == 2'h2 && hit) ? 1 : clr ? 1 << 20 : eff(dl);
        moved = 0;
        d0    = dones;
        wr(`ADDR_STATUS, 32'h6);
        wr(`ADDR_DST_LENGTH, {16'h0, dl});
        wr(`ADDR_SRC_LENGTH, {16'h0, sl});
        wr(`ADDR_CELL_LENGTH, {16'h0, cl});
        wr(`ADDR_MATCH_VALUE, {24'h0, mt});
        wr(`ADDR_CONTROL, {29'h0, md, 1'b1});
        for (int c = 0; c < cells && moved < total; c++) begin
            a0 = acks;
            n  = 0;
            @(posedge clk);
            cell_trigger <= 1'b1;
            @(posedge clk);
            cell_trigger <= 1'b0;
            @(posedge clk);
            while (byte_req === 1'b1 && n < 2000) begin
                @(posedge clk);
                n++;
            end
            want  = (eff(cl) < total - moved) ? eff(cl) : total - moved;
            moved += want;
            cmp32("cell bytes", want, acks - a0);
            if (md != 2'h2 || !hit) begin
                chk_reg("dst progress", `ADDR_DST_PROGRESS, clr ? 0 : moved % eff(dl));
                chk_reg("src progress", `ADDR_SRC_PROGRESS, clr ? 0 : moved % eff(sl));
            end
        end
        apb(1'b0, `ADDR_STATUS, 32'h0, q, e);
        cmp32("terminated", md == 2'h2 && hit, q[2]);
        cmp32("busy bit", moved != total, q[0]);
        cmp32("busy pin", moved != total, busy);
        cmp32("done pulses", moved == total, dones - d0);
        chk_reg("control", `ADDR_CONTROL, {29'h0, md, moved != total});
        if (moved != total) begin
            wr(`ADDR_CONTROL, 32'h0);
            chk_reg("status after abort", `ADDR_STATUS, 32'h0);
        end
    endtask

    initial begin
        logic [31:0] v, q;
        logic        e;
        v = $urandom(32'h96d5);
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 32; a += 4) chk_reg("reset value", a[7:0], 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            wr(`ADDR_DST_LENGTH, v);
            chk_reg("dst length", `ADDR_DST_LENGTH, {16'h0, v[15:0]});
            wr(`ADDR_CELL_LENGTH, ~v);
            chk_reg("cell length", `ADDR_CELL_LENGTH, {16'h0, ~v[15:0]});
            wr(`ADDR_SRC_PROGRESS, v);
            wr(`ADDR_DST_PROGRESS, v);
            chk_reg("src progress ro", `ADDR_SRC_PROGRESS, 32'h0);
            chk_reg("dst progress ro", `ADDR_DST_PROGRESS, 32'h0);
            wr(`ADDR_MATCH_VALUE, v);
            chk_reg("match value", `ADDR_MATCH_VALUE, {24'h0, v[7:0]});
        end
        apb(1'b0, 8'h20, 32'h0, q, e);
        cmp32("unmapped error", 32'h1, {31'h0, e});
        cmp32("unmapped data", 32'h0, q);
        apb(1'b1, 8'h09, 32'hffff, q, e);
        cmp32("misaligned error", 32'h1, {31'h0, e});
        chk_reg("misaligned ignored", `ADDR_SRC_LENGTH, 32'h0);
        for (int i = 0; i < 6; i++) begin
            slow <= 1'($urandom_range(1));
            fill <= 8'($urandom());
            @(posedge clk);
            run(2'h0, 16'($urandom_range(12, 1)), 16'($urandom_range(5, 1)), 16'($urandom_range(7, 1)), ~fill, 20);
        end
        run(2'h0, 16'h0001, 16'h0001, 16'h0001, ~fill, 2);
        run(2'h0, 16'h0000, 16'h0100, 16'h0000, ~fill, 1);
        run(2'h0, 16'h0006, 16'h0006, 16'h0004, fill, 2);
        run(2'h2, 16'h0006, 16'h0006, 16'h0004, fill, 2);
        run(2'h1, 16'h0003, 16'h0005, 16'h0002, fill, 2);
        run(2'h1, 16'h0005, 16'h0002, 16'h0003, ~fill, 3);
        report_and_stop();
    end
endmodule
